// file: rtl/sac_params.svh
// Constants for the serial command and auto-connect controller.
// Assumes a 100 MHz system clock; included by the controller RTL.
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

`define SAC_CLK_HZ          100000000
`define SAC_TICK_MS         10
`define SAC_TICK_CYC        ((`SAC_CLK_HZ / 1000) * `SAC_TICK_MS)
`define SAC_GAP_MS          1000
`define SAC_GAP_TICKS       (`SAC_GAP_MS / `SAC_TICK_MS)
`define SAC_BAUD_DEFAULT    9600
`define SAC_BIT_CYC         (`SAC_CLK_HZ / `SAC_BAUD_DEFAULT)
`define SAC_PROFILES        2
`define SAC_LINE_MAX        16
`define SAC_FIFO_DEPTH      32
`define SAC_CH_CR           8'h0d
`define SAC_CH_LF           8'h0a
`define SAC_CH_A            8'h41
`define SAC_CH_SLASH        8'h2f
`define SAC_CH_PLUS         8'h2b
`define SAC_CH_ZERO         8'h30
`define SAC_CH_O            8'h4f
`define SAC_CH_K            8'h4b
`define SAC_CH_E            8'h45
`define SAC_CH_R            8'h52

`endif

// file: rtl/sac_pkg.sv
// Types shared by the auto-connect controller files.
// Assumes sac_params.svh is on the include path.
package sac_pkg;
    // Network entity selected by the active profile
    typedef enum logic [1:0] {
        SAC_TCP_CLIENT = 2'h0,
        SAC_TCP_SERVER = 2'h1,
        SAC_UDP_CLIENT = 2'h2,
        SAC_UDP_SERVER = 2'h3
    } sac_net_mode_t;

    // Top-level operating state, one-hot
    typedef enum logic [4:0] {
        SAC_ST_IDLE  = 5'h01,
        SAC_ST_ASSOC = 5'h02,
        SAC_ST_CONN  = 5'h04,
        SAC_ST_PASS  = 5'h08,
        SAC_ST_CMD   = 5'h10
    } sac_state_t;
endpackage

// file: rtl/sac_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronised active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sac_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // Discard all contents
    input  wire logic             flush
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];   // Flip-flop storage
    logic [AW-1:0]    wr_q;            // Write index
    logic [AW-1:0]    rd_q;            // Read index
    logic [AW:0]      cnt_q;           // Occupancy
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;
    assign out_data  = mem_q[rd_q];

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// file: rtl/sac_ctrl.sv
// Serial command interpreter and auto-connect sequencer.
// Assumes byte-wide UART streams outside; network results are inputs.
`include "sac_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sac_ctrl
    import sac_pkg::*;
#(
    parameter int TICK_CYC  = `SAC_TICK_CYC,
    parameter int GAP_TICKS = `SAC_GAP_TICKS,
    parameter int LINE_MAX  = `SAC_LINE_MAX,
    parameter int DEPTH     = `SAC_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Profiles from storage
    input  wire logic [15:0] prof_assoc_to [`SAC_PROFILES],
    input  wire logic [15:0] prof_conn_to  [`SAC_PROFILES],
    input  wire logic [1:0]  prof_net_mode [`SAC_PROFILES],
    input  wire logic        prof_echo     [`SAC_PROFILES],
    input  wire logic [23:0] prof_baud     [`SAC_PROFILES],
    input  wire logic        prof_valid    [`SAC_PROFILES],
    input  wire logic        prof_sel,
    input  wire logic        auto_en,
    // Host-side settings
    input  wire logic        verbose_clr,
    input  wire logic        verbose_set,
    // Serial receive byte stream
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    // Serial transmit byte stream
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [7:0]       tx_data,
    // Serial format to the UART
    output logic [23:0]      baud_rate,
    // Command executor
    output logic             cmd_go,
    output logic             cmd_repeat,
    output logic [7:0]       cmd_len,
    input  wire logic        cmd_done,
    input  wire logic        cmd_ok,
    input  wire logic [3:0]  cmd_err,
    input  wire logic        cmd_detail,
    // Network status
    input  wire logic        net_assoc,
    input  wire logic        net_up,
    input  wire logic        net_down,
    input  wire logic        net_rx_seen,
    // Outputs of state
    output logic             pass_mode,
    output logic             cmd_mode,
    output logic             net_start,
    output logic             peer_latch
);
    sac_state_t  st_q;
    logic        rst_m_q, rst_s_q;           // Reset release pair
    logic        verbose_q;                  // Response format
    logic [7:0]  len_q;                      // Bytes in current line
    logic        sawcr_q;                    // Last byte was CR
    logic        slash_q;                    // Line began A/
    logic        first_a_q;                  // First byte was A
    logic [31:0] cyc_q;                      // Cycles within a tick
    logic [15:0] tick_q;                     // Ticks elapsed
    logic [1:0]  plus_q;                     // Pluses seen
    logic        armed_q;                    // Three pluses seen
    logic        resp_busy_q;                // Response in progress
    logic [2:0]  resp_ix_q;                  // Response byte index
    logic [2:0]  resp_len_q;
    logic [7:0]  resp_buf_q [5];             // Response text
    logic        echo_v;
    logic        rsp_v;
    logic        fifo_rdy;
    logic [7:0]  tx_byte;
    logic        tx_push;
    logic        tick;
    logic        ps;
    sac_net_mode_t mode;

    // Synchronised reset used by everything below
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // Profile selection; invalid profile falls back to 9600 baud
    assign ps        = prof_sel;
    assign mode      = sac_net_mode_t'(prof_net_mode[ps]);
    assign baud_rate = prof_valid[ps] ? prof_baud[ps]
                                      : 24'(`SAC_BAUD_DEFAULT);
    assign pass_mode = (st_q == SAC_ST_PASS);
    assign cmd_mode  = (st_q == SAC_ST_CMD);

    // Ten millisecond tick, restarted on each net_start and each byte received in pass-through
    assign tick = (cyc_q == 32'(TICK_CYC - 1));

    // Verbose setting, on after reset
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            verbose_q <= 1'b1;
        end else if (verbose_clr) begin
            verbose_q <= 1'b0;
        end else if (verbose_set) begin
            verbose_q <= 1'b1;
        end
    end

    // Timer for association, connection and escape gap
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            cyc_q  <= '0;
            tick_q <= '0;
        end else if (net_start || (pass_mode && rx_valid)) begin
            cyc_q  <= '0;
            tick_q <= '0;
        end else begin
            cyc_q <= tick ? '0 : cyc_q + 1'b1;
            if (tick && tick_q != 16'hffff) begin
                tick_q <= tick_q + 1'b1;
            end
        end
    end

    // Auto-connect sequencer
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            st_q      <= SAC_ST_IDLE;
            net_start <= 1'b0;
        end else begin
            net_start <= 1'b0;
            case (st_q)
                SAC_ST_IDLE: begin
                    net_start <= auto_en;
                    st_q <= auto_en ? SAC_ST_ASSOC : SAC_ST_CMD;
                end
                SAC_ST_ASSOC: begin
                    if (net_assoc) begin
                        net_start <= 1'b1;
                        st_q      <= SAC_ST_CONN;
                    end else if (tick_q >= prof_assoc_to[ps]) begin
                        st_q <= SAC_ST_CMD;
                    end
                end
                SAC_ST_CONN: begin
                    case (mode)
                        SAC_TCP_CLIENT: begin
                            if (net_up) begin
                                st_q <= SAC_ST_PASS;
                            end else if (!net_start
                                         && tick_q >= prof_conn_to[ps]) begin
                                st_q <= SAC_ST_CMD;
                            end
                        end
                        SAC_UDP_CLIENT: begin
                            st_q <= SAC_ST_PASS;
                        end
                        default: begin
                            // Servers: pass-through covers waiting too
                            st_q <= SAC_ST_PASS;
                        end
                    endcase
                end
                SAC_ST_PASS: begin
                    if (armed_q && tick_q >= 16'(GAP_TICKS)) begin
                        st_q <= SAC_ST_CMD;
                    end else if (net_down && mode == SAC_TCP_CLIENT) begin
                        st_q <= SAC_ST_CMD;
                    end
                end
                SAC_ST_CMD: begin
                    st_q <= SAC_ST_CMD;
                end
                default: begin
                    st_q <= SAC_ST_CMD;
                end
            endcase
        end
    end

    // Server peers: TCP waits for next client, UDP tracks last sender
    assign peer_latch = pass_mode && (((mode == SAC_TCP_SERVER) && net_up)
                      || ((mode == SAC_UDP_SERVER) && net_rx_seen));

    // Escape detector: exactly three pluses then silence
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            plus_q  <= '0;
            armed_q <= 1'b0;
        end else if (!pass_mode) begin
            plus_q  <= '0;
            armed_q <= 1'b0;
        end else if (rx_valid) begin
            if (rx_data == `SAC_CH_PLUS && !armed_q) begin
                plus_q  <= (plus_q == 2'd2) ? 2'd0 : plus_q + 1'b1;
                armed_q <= (plus_q == 2'd2);
            end else begin
                plus_q  <= '0;
                armed_q <= 1'b0;
            end
        end
    end

    // Line assembly; only whole lines are handed on
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            len_q   <= '0;
            sawcr_q <= 1'b0;
            slash_q <= 1'b0;
            cmd_go  <= 1'b0;
            cmd_repeat <= 1'b0;
            cmd_len <= '0;
        end else begin
            cmd_go <= 1'b0;
            if (!cmd_mode) begin
                len_q   <= '0;
                sawcr_q <= 1'b0;
                slash_q <= 1'b0;
            end else if (rx_valid) begin
                sawcr_q <= (rx_data == `SAC_CH_CR);
                if (sawcr_q && rx_data == `SAC_CH_LF) begin
                    cmd_go     <= 1'b1;
                    cmd_repeat <= slash_q;
                    cmd_len    <= (len_q == 8'd0) ? 8'd0 : len_q - 1'b1;
                    len_q      <= '0;
                    slash_q    <= 1'b0;
                end else begin
                    if (len_q < 8'(LINE_MAX)) begin
                        len_q <= len_q + 1'b1;
                    end
                    if (len_q == 8'd1 && first_a_q
                        && rx_data == `SAC_CH_SLASH) begin
                        slash_q <= 1'b1;
                    end
                end
            end
        end
    end

    // Remember whether the line opened with A
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            first_a_q <= 1'b0;
        end else if (cmd_mode && rx_valid && len_q == 8'd0) begin
            first_a_q <= (rx_data == `SAC_CH_A);
        end
    end

    // Response builder: OK, ERROR, or a digit, then CR LF
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            resp_busy_q <= 1'b0;
            resp_ix_q   <= '0;
            resp_len_q  <= '0;
            for (int i = 0; i < 5; i++) begin
                resp_buf_q[i] <= 8'h00;
            end
        end else if (cmd_done && !resp_busy_q) begin
            resp_busy_q <= 1'b1;
            resp_ix_q   <= '0;
            if (!verbose_q) begin
                resp_buf_q[0] <= cmd_ok ? `SAC_CH_ZERO
                                        : `SAC_CH_ZERO + {4'h0, cmd_err};
                resp_len_q    <= 3'd1;
            end else if (cmd_ok) begin
                resp_buf_q[0] <= `SAC_CH_O;
                resp_buf_q[1] <= `SAC_CH_K;
                resp_len_q    <= 3'd2;
            end else begin
                resp_buf_q[0] <= `SAC_CH_E;
                resp_buf_q[1] <= `SAC_CH_R;
                resp_buf_q[2] <= `SAC_CH_R;
                resp_buf_q[3] <= `SAC_CH_O;
                resp_buf_q[4] <= `SAC_CH_R;
                resp_len_q    <= 3'd5;
            end
        end else if (rsp_v && fifo_rdy) begin
            if (resp_ix_q == resp_len_q + 3'd1) begin
                resp_busy_q <= 1'b0;
            end
            resp_ix_q <= resp_ix_q + 1'b1;
        end
    end

    // Echo has priority; response bytes wait behind it
    assign echo_v  = cmd_mode && rx_valid && prof_echo[ps];
    assign rsp_v   = resp_busy_q && !echo_v;
    assign tx_push = echo_v || rsp_v;
    always_comb begin
        if (echo_v) begin
            tx_byte = rx_data;
        end else if (resp_ix_q < resp_len_q) begin
            tx_byte = resp_buf_q[resp_ix_q];
        end else if (resp_ix_q == resp_len_q) begin
            tx_byte = `SAC_CH_CR;
        end else begin
            tx_byte = `SAC_CH_LF;
        end
    end

    // Transmit FIFO; echo bytes dropped when it is full
    sac_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .clk       (clk),
        .rst_b     (rst_s_q),
        .in_valid  (tx_push),
        .in_ready  (fifo_rdy),
        .in_data   (tx_byte),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data),
        .flush     (1'b0)
    );

    // Unused detail flag kept for ERROR suffix by executor
    logic unused_ok;
    assign unused_ok = cmd_detail & first_a_q;

    // Result checks
    property p_verbose_reset;
        @(posedge clk) $rose(rst_s_q) |-> verbose_q;
    endproperty
    a_verbose_reset: assert property (p_verbose_reset) else $error("verbose");

    property p_partial_drop;
        @(posedge clk) disable iff (!rst_s_q)
            !cmd_mode |=> len_q == 8'd0;
    endproperty
    a_partial_drop: assert property (p_partial_drop) else $error("partial");

    property p_udp_client;
        @(posedge clk) disable iff (!rst_s_q)
            st_q == SAC_ST_CONN && mode == SAC_UDP_CLIENT |=> pass_mode;
    endproperty
    a_udp_client: assert property (p_udp_client) else $error("udp");

    property p_tcp_drop;
        @(posedge clk) disable iff (!rst_s_q)
            pass_mode && net_down && mode == SAC_TCP_CLIENT |=> cmd_mode;
    endproperty
    a_tcp_drop: assert property (p_tcp_drop) else $error("tcp drop");

    property p_line_go;
        @(posedge clk) disable iff (!rst_s_q)
            cmd_mode && rx_valid && sawcr_q && rx_data == `SAC_CH_LF
            |=> cmd_go;
    endproperty
    a_line_go: assert property (p_line_go) else $error("line");

    property p_assoc_ok;
        @(posedge clk) disable iff (!rst_s_q)
            st_q == SAC_ST_ASSOC && net_assoc |=> st_q == SAC_ST_CONN;
    endproperty
    a_assoc_ok: assert property (p_assoc_ok) else $error("assoc");

    property p_echo;
        @(posedge clk) disable iff (!rst_s_q)
            echo_v |-> tx_push && tx_byte == rx_data;
    endproperty
    a_echo: assert property (p_echo) else $error("echo");

    property p_server_stay;
        @(posedge clk) disable iff (!rst_s_q)
            pass_mode && mode == SAC_TCP_SERVER && !armed_q |=> pass_mode;
    endproperty
    a_server_stay: assert property (p_server_stay) else $error("srv");
endmodule
`default_nettype wire

// file: test/sac_host.sv
// Host processor model on the controller's serial byte streams.
// Assumes the bench calls its tasks; it drives on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module sac_host (
    // Clock
    input  wire logic       clk,
    // Stall request from the bench
    input  wire logic       stall,
    // Serial streams
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data
);
    logic [7:0] got [$];  // Bytes taken from the controller

    // Quiet start so nothing is taken before the bench begins
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end

    // Ready moves only off the sampling edge
    always @(negedge clk) tx_ready <= ~stall;

    // Take a byte at the edge that sees valid and ready together
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got.push_back(tx_data);
        end
    end

    // One byte; idle data flips so a stale byte cannot pass as new
    task automatic send(input logic [7:0] b);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data  = b;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data  = ~b;
    endtask

    // Escape: three plus signs, then the caller stays silent
    task automatic escape();
        repeat (3) send(8'h2b);
    endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the serial command and auto-connect controller.
// Assumes the host model is compiled first and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sac_pkg::*;
;
    logic        clk, rst_b, stall, hold;   // Clock, reset, stall control
    logic [15:0] a_to [2], c_to [2];        // Profile timeouts in ticks
    logic [1:0]  n_md [2];                  // Profile network modes
    logic        p_echo [2], p_val [2];     // Profile echo and valid
    logic [23:0] p_baud [2], baud_rate;     // Serial rates
    logic        p_sel, auto_en, v_clr, v_set;
    logic        rx_valid, tx_valid, tx_ready, cmd_go, cmd_repeat;
    logic [7:0]  rx_data, tx_data, cmd_len;
    logic        cmd_done, cmd_ok, c_det;
    logic [3:0]  cmd_err;
    logic        n_as, n_up, n_dn, n_rx;    // Network results
    logic        pass_mode, cmd_mode, net_start, peer_latch;
    logic [7:0]  exp_q [$];                 // Model of the transmit stream
    logic [31:0] seed, seed2;               // Random states
    int          fails, cmp_count, go_n, st_n;
    bit          vb, ech;                   // Model verbose and echo

    // Short counts keep the timeout runs brief
    sac_ctrl #(.TICK_CYC(4), .GAP_TICKS(3)) dut (
        .clk(clk), .rst_b(rst_b), .prof_assoc_to(a_to),
        .prof_conn_to(c_to), .prof_net_mode(n_md), .prof_echo(p_echo),
        .prof_baud(p_baud), .prof_valid(p_val), .prof_sel(p_sel),
        .auto_en(auto_en), .verbose_clr(v_clr), .verbose_set(v_set),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .baud_rate(baud_rate),
        .cmd_go(cmd_go), .cmd_repeat(cmd_repeat), .cmd_len(cmd_len),
        .cmd_done(cmd_done), .cmd_ok(cmd_ok), .cmd_err(cmd_err),
        .cmd_detail(c_det), .net_assoc(n_as), .net_up(n_up),
        .net_down(n_dn), .net_rx_seen(n_rx), .pass_mode(pass_mode),
        .cmd_mode(cmd_mode), .net_start(net_start), .peer_latch(peer_latch));

    sac_host host (.clk(clk), .stall(stall), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Random stalls; hold forces a full stop for the buffer test
    always @(negedge clk) begin
        seed2 = lfsr(seed2);
        stall <= hold | (seed2[0] & seed2[2]);
    end

    // Count command and connect pulses as they land
    always @(posedge clk) begin
        if (cmd_go === 1'b1) go_n <= go_n + 1;
        if (net_start === 1'b1) st_n <= st_n + 1;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] want);
        cmp_count++;
        if (got !== want) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    // Compare the host's received bytes with the model stream
    task automatic chk_tx(input int lim);
        int k;
        k = 0;
        while (host.got.size() < exp_q.size() && k < lim) begin
            @(negedge clk);
            k++;
        end
        repeat (40) @(negedge clk);
        chk(24'(host.got.size()), 24'(exp_q.size()));
        foreach (exp_q[i]) begin
            if (i < host.got.size()) chk(host.got[i], exp_q[i]);
        end
        host.got.delete();
        exp_q.delete();
    endtask

    // Reset held two cycles; model state returns to its defaults
    task automatic do_reset();
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        vb = 1'b1;
        repeat (4) @(negedge clk);
        host.got.delete();
        exp_q.delete();
        st_n = 0;
    endtask

    // A host byte; its echo is expected when echo is on
    task automatic put(input logic [7:0] b);
        host.send(b);
        if (ech) exp_q.push_back(b);
    endtask

    // Response text per verbose setting, then CR LF
    task automatic resp(input logic ok, input logic [3:0] e);
        string s;
        if (vb && ok) s = "OK";
        else if (vb) s = "ERROR";
        else begin
            s = " ";
            s[0] = 8'h30 + (ok ? 8'h00 : {4'h0, e});
        end
        foreach (s[i]) exp_q.push_back(s[i]);
        exp_q.push_back(8'h0d);
        exp_q.push_back(8'h0a);
    endtask

    // One command line, executor result and answer
    task automatic cmd(input bit rep, input int n, input logic ok,
                       input logic [3:0] e);
        int g;
        int k;
        g = go_n;
        if (rep) begin
            put(8'h41);
            put(8'h2f);
        end
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            put((!rep && i == 1) ? 8'h2f : 8'h42 + {4'h0, seed[3:0]});
        end
        put(8'h0d);
        chk(24'(go_n), 24'(g));
        put(8'h0a);
        k = 0;
        while (go_n == g && k < 4) begin
            @(negedge clk);
            k++;
        end
        chk(24'(go_n), 24'(g + 1));
        chk(cmd_repeat, rep);
        chk(cmd_len, 24'(n + (rep ? 2 : 0)));
        @(negedge clk);
        cmd_done = 1'b1;
        c_det    = seed[5];
        cmd_ok   = ok;
        cmd_err  = e;
        @(negedge clk);
        cmd_done = 1'b0;
        resp(ok, e);
        chk_tx(400);
    endtask

    task automatic set_verb(input bit v);
        @(negedge clk);
        v_clr = ~v;
        v_set = v;
        @(negedge clk);
        v_clr = 1'b0;
        v_set = 1'b0;
        vb = v;
    endtask

    // Wait, bounded, for pass mode (ps) or command mode
    task automatic wait_md(input bit ps, input int lim);
        int k;
        k = 0;
        while ((ps ? pass_mode : cmd_mode) !== 1'b1 && k < lim) begin
            @(negedge clk);
            k++;
        end
    endtask

    // Start-up with auto-connect in a given network mode
    task automatic boot(input logic [1:0] m, input logic as,
                        input logic up);
        n_md[1] = m;
        auto_en = 1'b1;
        n_as    = 1'b0;
        n_up    = 1'b0;
        n_rx    = 1'b0;
        do_reset();
        n_as = as;
        n_up = up;
        n_rx = up;
    endtask

    task automatic finish_test();
        if (fails == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #600000;
        fails++;
        finish_test();
    end

    initial begin
        rst_b = 1'b0; hold = 1'b0; stall = 1'b0;
        seed = 32'hb03f72a6; seed2 = 32'hb03f72a6 ^ 32'h5a5a5a5a;
        a_to = '{16'h0008, 16'h0008}; c_to = '{16'h0008, 16'h0008};
        n_md = '{2'h0, 2'h0}; p_echo = '{1'b0, 1'b1};
        p_val = '{1'b0, 1'b1}; p_baud = '{24'h000000, 24'h01c200};
        p_sel = 1'b1; auto_en = 1'b0; v_clr = 1'b0; v_set = 1'b0;
        cmd_done = 1'b0; cmd_ok = 1'b0; cmd_err = 4'h0; c_det = 1'b0;
        n_as = 1'b0; n_up = 1'b0; n_dn = 1'b0; n_rx = 1'b0;
        fails = 0; cmp_count = 0; go_n = 0; st_n = 0; ech = 1'b1;
        do_reset();
        chk(cmd_mode, 1'b1);
        chk(baud_rate, 24'h01c200);
        p_sel = 1'b0;
        ech   = 1'b0;
        @(negedge clk);
        chk(baud_rate, 24'd9600);
        cmd(1'b0, 3, 1'b0, 4'h1);
        p_sel = 1'b1;
        ech   = 1'b1;
        cmd(1'b0, 5, 1'b1, 4'h0);
        cmd(1'b0, 3, 1'b0, 4'h3);
        cmd(1'b1, 0, 1'b1, 4'h0);
        set_verb(1'b0);
        cmd(1'b0, 2, 1'b1, 4'h0);
        cmd(1'b0, 2, 1'b0, 4'h5);
        set_verb(1'b1);
        cmd(1'b0, 1, 1'b1, 4'h0);
        set_verb(1'b0);
        // Fill the transmit buffer with echoes until it refuses
        hold = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 40; i++) begin
            host.send(8'h61 + 8'(i % 20));
            if (i < 32) exp_q.push_back(8'h61 + 8'(i % 20));
        end
        hold = 1'b0;
        chk_tx(600);
        p_val[1] = 1'b0;
        do_reset();
        chk(baud_rate, 24'd9600);
        cmd(1'b0, 2, 1'b1, 4'h0);
        // Auto-connect: association timeout
        boot(2'h0, 1'b0, 1'b0);
        repeat (10) @(negedge clk);
        chk(cmd_mode, 1'b0);
        wait_md(1'b0, 150);
        chk(cmd_mode, 1'b1);
        chk(pass_mode, 1'b0);
        // Connection timeout in TCP client mode, after a slow association
        c_to[1] = 16'h0004;
        boot(2'h0, 1'b0, 1'b0);
        repeat (20) @(negedge clk);
        n_as = 1'b1;
        repeat (8) @(negedge clk);
        chk(cmd_mode, 1'b0);
        wait_md(1'b0, 150);
        chk(cmd_mode, 1'b1);
        chk(24'(st_n > 0), 24'h1);
        // Every network mode connects, then escapes
        for (int m = 0; m < 4; m++) begin
            boot(2'(m), 1'b1, 1'b1);
            wait_md(1'b1, 100);
            chk(pass_mode, 1'b1);
            chk(peer_latch, 24'(m % 2));
            host.escape();
            chk(cmd_mode, 1'b0);
            wait_md(1'b0, 80);
            chk(cmd_mode, 1'b1);
        end
        // TCP client drop ends pass-through; traffic is not a command
        boot(2'h0, 1'b1, 1'b1);
        wait_md(1'b1, 100);
        st_n = go_n;
        host.send(8'h0d);
        host.send(8'h0a);
        repeat (4) @(negedge clk);
        chk(24'(go_n), 24'(st_n));
        n_up = 1'b0;
        n_dn = 1'b1;
        @(negedge clk);
        n_dn = 1'b0;
        wait_md(1'b0, 20);
        chk(cmd_mode, 1'b1);
        // TCP server keeps waiting after its client leaves
        boot(2'h1, 1'b1, 1'b0);
        wait_md(1'b1, 100);
        n_dn = 1'b1;
        @(negedge clk);
        n_dn = 1'b0;
        repeat (20) @(negedge clk);
        chk(pass_mode, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
